// ==== include/cmcs_defines.vh ====
// Constants for the configuration master clock select block
`ifndef CMCS_DEFINES_VH
`define CMCS_DEFINES_VH

// ----------------------------------------------------------------
// Oscillator and divider sizing
// ----------------------------------------------------------------
`define CMCS_OSC_KHZ 100000
`define CMCS_OSC_NOMINAL_KHZ 130000
`define CMCS_PERIOD_W 6
`define CMCS_CODE_W 4

// ----------------------------------------------------------------
// Nominal frequencies in kHz
// ----------------------------------------------------------------
`define CMCS_HW_DEFAULT_KHZ 3100
`define CMCS_F0_KHZ 2500
`define CMCS_F1_KHZ 4300
`define CMCS_F2_KHZ 5400
`define CMCS_F3_KHZ 6900
`define CMCS_F4_KHZ 8100
`define CMCS_F5_KHZ 9200
`define CMCS_F6_KHZ 10000
`define CMCS_F7_KHZ 13000
`define CMCS_F8_KHZ 15000
`define CMCS_F9_KHZ 20000
`define CMCS_F10_KHZ 26000
`define CMCS_F11_KHZ 33000

// ----------------------------------------------------------------
// Selection codes
// ----------------------------------------------------------------
`define CMCS_SW_DEFAULT_CODE 4'h0
`define CMCS_MAX_ENC_CODE 4'h8
`define CMCS_MAX_CODE 4'hb

// Oscillator cycles per master clock period, rounded to nearest
`define CMCS_PERIOD_OF(khz) ((`CMCS_OSC_KHZ + (khz) / 2) / (khz))
`define CMCS_HW_DEFAULT_PERIOD `CMCS_PERIOD_OF(`CMCS_HW_DEFAULT_KHZ)

`endif

// ==== hdl/cmcs_divider.v ====
// Glitch-free programmable divider producing the master clock
`timescale 1ns/1ps
`include "cmcs_defines.vh"

module cmcs_divider
#(
   parameter PERIOD_W = `CMCS_PERIOD_W
)
(
   clk,
   rstn,
   period_in,
   clk_out,
   period_active
);
   input wire clk;
   input wire rstn;
   input wire [PERIOD_W-1:0] period_in;
   output reg clk_out;
   output reg [PERIOD_W-1:0] period_active;

   localparam integer HW_PERIOD_INT = `CMCS_HW_DEFAULT_PERIOD;
   localparam [PERIOD_W-1:0] HW_PERIOD = HW_PERIOD_INT[PERIOD_W-1:0];
   localparam [PERIOD_W-1:0] ONE = {{(PERIOD_W-1){1'b0}}, 1'b1};

   reg [PERIOD_W-1:0] cnt_reg;
   reg [PERIOD_W-1:0] cnt_next;
   reg [PERIOD_W-1:0] period_next;
   wire wrap;

   assign wrap = (cnt_reg == period_active - ONE);

   // ----------------------------------------------------------------
   // Next count and period
   // ----------------------------------------------------------------
   // New period is taken only at the end of a whole period, so the
   // output never shows a shortened high or low phase
   always @*
   begin
      cnt_next = cnt_reg + ONE;
      period_next = period_active;
      if (wrap)
      begin
         cnt_next = {PERIOD_W{1'b0}};
         period_next = period_in;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // High for the first floor(P/2) cycles; odd periods lean low
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         // Parked on the last count so the first edge opens a whole high phase
         cnt_reg <= HW_PERIOD - ONE;
         period_active <= HW_PERIOD;
         clk_out <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         period_active <= period_next;
         clk_out <= (cnt_next < (period_next >> 1));
      end
   end
endmodule

// ==== hdl/cmcs_top.v ====
// Configuration master clock generator and frequency select
`timescale 1ns/1ps
`include "cmcs_defines.vh"

module cmcs_top
(
   clk,
   rstn,
   cfg_sel_valid,
   cfg_sel_explicit,
   cfg_sel_code,
   cfg_encrypt_en,
   config_master_clock,
   user_master_clock,
   osc_user_clk,
   mclk_sel_applied,
   mclk_code,
   mclk_period,
   mclk_sel_limit_err
);
   input wire clk;
   input wire rstn;
   input wire cfg_sel_valid;
   input wire cfg_sel_explicit;
   input wire [`CMCS_CODE_W-1:0] cfg_sel_code;
   input wire cfg_encrypt_en;
   output wire config_master_clock;
   output wire user_master_clock;
   output wire osc_user_clk;
   output reg mclk_sel_applied;
   output reg [`CMCS_CODE_W-1:0] mclk_code;
   output wire [`CMCS_PERIOD_W-1:0] mclk_period;
   output reg mclk_sel_limit_err;

   localparam integer HW_PERIOD_INT = `CMCS_HW_DEFAULT_PERIOD;
   localparam [`CMCS_PERIOD_W-1:0] HW_PERIOD = HW_PERIOD_INT[`CMCS_PERIOD_W-1:0];
   localparam [`CMCS_CODE_W-1:0] SW_CODE = `CMCS_SW_DEFAULT_CODE;

   reg [`CMCS_CODE_W-1:0] code_next;
   reg [`CMCS_PERIOD_W-1:0] period_sel;
   wire divided_clk;

   // ----------------------------------------------------------------
   // Code to period lookup
   // ----------------------------------------------------------------
   // Unlisted codes fall back to the software default
   function [`CMCS_PERIOD_W-1:0] code_period;
      input [`CMCS_CODE_W-1:0] code;
      integer p;
      begin
         case (code)
            4'h0: p = `CMCS_PERIOD_OF(`CMCS_F0_KHZ);
            4'h1: p = `CMCS_PERIOD_OF(`CMCS_F1_KHZ);
            4'h2: p = `CMCS_PERIOD_OF(`CMCS_F2_KHZ);
            4'h3: p = `CMCS_PERIOD_OF(`CMCS_F3_KHZ);
            4'h4: p = `CMCS_PERIOD_OF(`CMCS_F4_KHZ);
            4'h5: p = `CMCS_PERIOD_OF(`CMCS_F5_KHZ);
            4'h6: p = `CMCS_PERIOD_OF(`CMCS_F6_KHZ);
            4'h7: p = `CMCS_PERIOD_OF(`CMCS_F7_KHZ);
            4'h8: p = `CMCS_PERIOD_OF(`CMCS_F8_KHZ);
            4'h9: p = `CMCS_PERIOD_OF(`CMCS_F9_KHZ);
            4'ha: p = `CMCS_PERIOD_OF(`CMCS_F10_KHZ);
            4'hb: p = `CMCS_PERIOD_OF(`CMCS_F11_KHZ);
            default: p = `CMCS_PERIOD_OF(`CMCS_F0_KHZ);
         endcase
         // All table periods fit the counter width, so the cut loses nothing
         code_period = p[`CMCS_PERIOD_W-1:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // Selection decode
   // ----------------------------------------------------------------
   // A missing or out-of-table choice lands on the software default
   always @*
   begin
      code_next = SW_CODE;
      if (cfg_sel_explicit && (cfg_sel_code <= `CMCS_MAX_CODE))
      begin
         code_next = cfg_sel_code;
      end
   end

   // ----------------------------------------------------------------
   // Selection register
   // ----------------------------------------------------------------
   // Hardware default holds until the selection bits are taken.
   // The encryption ceiling is the source's duty; a breach is only
   // flagged, since clamping would silently change the chosen rate.
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mclk_sel_applied <= 1'b0;
         mclk_code <= SW_CODE;
         mclk_sel_limit_err <= 1'b0;
      end
      else if (cfg_sel_valid)
      begin
         mclk_sel_applied <= 1'b1;
         mclk_code <= code_next;
         mclk_sel_limit_err <= cfg_encrypt_en ? (code_next > `CMCS_MAX_ENC_CODE) : 1'b0;
      end
   end

   // Period requested of the divider
   always @*
   begin
      period_sel = mclk_sel_applied ? code_period(mclk_code) : HW_PERIOD;
   end

   // ----------------------------------------------------------------
   // Divider from the oscillator clock
   // ----------------------------------------------------------------
   cmcs_divider
   #(
      .PERIOD_W(`CMCS_PERIOD_W)
   )
   u_div
   (
      .clk(clk),
      .rstn(rstn),
      .period_in(period_sel),
      .clk_out(divided_clk),
      .period_active(mclk_period)
   );

   // ----------------------------------------------------------------
   // Clock outputs
   // ----------------------------------------------------------------
   // Nothing stops either clock once running
   assign config_master_clock = divided_clk;
   assign user_master_clock = divided_clk;
   assign osc_user_clk = clk;
endmodule

// ==== tb/cmcs_top_sva.sv ====
// Checker for the master clock select block
`timescale 1ns/1ps
module cmcs_chk (
   input wire logic clk, rstn, cfg_sel_valid, cfg_sel_explicit, cfg_encrypt_en,
   input wire logic config_master_clock, user_master_clock, mclk_sel_applied,
   input wire logic mclk_sel_limit_err,
   input wire logic [3:0] cfg_sel_code, mclk_code,
   input wire logic [5:0] mclk_period
);
   // ----------------------------------------
   // Sequences and properties
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_take;
      cfg_sel_valid && cfg_sel_explicit && cfg_sel_code <= 4'hb;
   endsequence
   sequence s_hw_high;
      config_master_clock [*8] ##1 config_master_clock [*8];
   endsequence
   property p_applied; cfg_sel_valid |=> mclk_sel_applied; endproperty
   property p_code; s_take |=> mclk_code == $past(cfg_sel_code); endproperty
   property p_dflt; cfg_sel_valid && !cfg_sel_explicit |=> mclk_code == 4'h0; endproperty
   property p_err;
      s_take and cfg_encrypt_en && cfg_sel_code > 4'h8 |=> mclk_sel_limit_err;
   endproperty
   property p_hold; !cfg_sel_valid |=> $stable(mclk_code); endproperty
   // Shortest legal low phase is two cycles, so anything less is a runt
   property p_low; $fell(config_master_clock) |-> !config_master_clock [*2]; endproperty
   property p_hw;
      $rose(config_master_clock) && mclk_period == 6'd32 |-> s_hw_high ##1 !config_master_clock;
   endproperty
   property p_user; user_master_clock == config_master_clock; endproperty
   a_applied: assert property (p_applied) else $error("selection not applied");
   a_code: assert property (p_code) else $error("wrong code taken");
   a_dflt: assert property (p_dflt) else $error("no default code");
   a_err: assert property (p_err) else $error("limit breach not flagged");
   a_hold: assert property (p_hold) else $error("code moved without selection");
   a_low: assert property (p_low) else $error("runt low phase");
   a_hw: assert property (p_hw) else $error("default high phase wrong");
   a_user: assert property (p_user) else $error("user clock differs");
endmodule
bind cmcs_top cmcs_chk u_cmcs_chk (.*);

// ==== tb/cmcs_src.sv ====
// Model of the bitstream source that hands over the clock selection
`timescale 1ns/1ps
module cmcs_src (
   input wire logic clk, go, expl, enc,
   input wire logic [3:0] code,
   output logic cfg_sel_valid, cfg_sel_explicit, cfg_encrypt_en,
   output logic [3:0] cfg_sel_code
);
   // One-cycle pulse; fields flip when idle so nothing leans on stale bits
   initial {cfg_sel_valid, cfg_sel_explicit, cfg_encrypt_en, cfg_sel_code} = 7'h0;
   always @(posedge clk)
   begin
      cfg_sel_valid <= go;
      cfg_sel_explicit <= go ? expl : ~cfg_sel_explicit;
      cfg_encrypt_en <= go ? enc : ~cfg_encrypt_en;
      cfg_sel_code <= go ? code : ~cfg_sel_code;
   end
endmodule

// ==== tb/tb_cmcs_top.sv ====
// Testbench for the master clock select block
`timescale 1ns/1ps
module tb_cmcs_top;
   logic clk = 0, rstn = 0, go = 0, expl = 0, enc = 0;
   logic [3:0] code = 4'h0;
   wire v, e, en, cmc, umc, osc, app, err;
   wire [3:0] sc, mc;
   wire [5:0] per;
   int miscompares = 0, samples_checked = 0;
   logic [5:0] ptab [0:11] = '{40, 23, 19, 14, 12, 11, 10, 8, 7, 5, 4, 3};
   always #5 clk = ~clk;
   cmcs_src u_cmcs_src (.clk(clk), .go(go), .expl(expl), .enc(enc), .code(code),
      .cfg_sel_valid(v), .cfg_sel_explicit(e), .cfg_encrypt_en(en), .cfg_sel_code(sc));
   cmcs_top u_cmcs_top (.clk(clk), .rstn(rstn), .cfg_sel_valid(v), .cfg_sel_explicit(e),
      .cfg_sel_code(sc), .cfg_encrypt_en(en), .config_master_clock(cmc),
      .user_master_clock(umc), .osc_user_clk(osc), .mclk_sel_applied(app),
      .mclk_code(mc), .mclk_period(per), .mclk_sel_limit_err(err));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Edge counting is bounded so a stuck clock cannot hang the run
   task high_len(input logic [31:0] exp);
      int n, k;
      n = 0;
      k = 0;
      while (cmc !== 1'b0 && k < 99)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      while (cmc !== 1'b1 && k < 199)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      while (cmc === 1'b1 && n < 99)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(n, exp);
      // A spent bound means a stuck clock: count it and stop
      if (k >= 99 || n >= 99)
      begin
         miscompares++;
         finish_test();
      end
   endtask
   task sel(input logic [3:0] c, input logic x, input logic n);
      @(posedge clk);
      go <= 1'b1; code <= c; expl <= x; enc <= n;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
      chk(app, 1'b1);
   endtask
   task wait_per(input logic [5:0] exp);
      int k;
      k = 0;
      while (per !== exp && k < 100)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      chk(per, exp);
      if (k >= 100)
      begin
         miscompares++;
         finish_test();
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk({app, mc, per, err}, {1'b0, 4'h0, 6'd32, 1'b0});
      @(posedge clk);
      rstn <= 1'b1;
      high_len(16);
      #3;
      chk({osc, umc}, {clk, cmc});
   endtask
   task t_codes;
      for (int i = 0; i < 12; i++)
      begin
         sel(i[3:0], 1'b1, 1'b0);
         chk({mc, err}, {i[3:0], 1'b0});
         wait_per(ptab[i]);
         high_len(ptab[i] / 2);
      end
   endtask
   task t_fallback;
      sel(4'h7, 1'b0, 1'b0);
      chk(mc, 4'h0);
      wait_per(6'd40);
      // Code beyond the table falls back, so no ceiling breach either
      sel(4'hc, 1'b1, 1'b1);
      chk(mc, 4'h0);
      chk(err, 1'b0);
   endtask
   task t_encrypt;
      sel(4'h9, 1'b1, 1'b1);
      chk(err, 1'b1);
      sel(4'h8, 1'b1, 1'b1);
      chk(err, 1'b0);
      sel(4'hb, 1'b1, 1'b0);
      chk(err, 1'b0);
   endtask
   initial
   begin
      t_reset();
      t_codes();
      t_fallback();
      t_encrypt();
      t_reset();
      finish_test();
   end
endmodule
